// *** pkg/sgc_pkg.sv ***
// Purpose: shared constants and types for the scaler global control/status bank
// Assumes: byte-wide subaddressed register access
// Notes: control byte reset value is a plain default
package sgc_pkg;

  localparam logic [7:0] SGC_ADDR_CTRL = 8'h88;
  localparam logic [7:0] SGC_ADDR_STATUS = 8'h8f;
  localparam logic [7:0] SGC_CTRL_RST = 8'h00;
  localparam logic [7:0] SGC_RDATA_RST = 8'h00;
  localparam logic [7:0] SGC_UNMAPPED_RD = 8'h00;
  localparam logic [8:0] SGC_SAMPLE_RST = 9'h000;
  localparam int SGC_SAMPLE_W = 9;

  // control byte layout, msb first
  typedef struct packed {
    logic sample_port_select_hi;
    logic sample_port_select_lo;
    logic scaler_soft_reset_n;
    logic programmed_marker;
    logic audio_clock_sleep;
    logic reserved;
    logic scaler_sleep;
    logic decoder_sleep;
  } sgc_ctrl_t;

  // status byte layout, msb first
  typedef struct packed {
    logic expansion_tristate_pin;
    logic image_tristate_pin;
    logic fifo_almost_filled;
    logic fifo_overflow;
    logic programmed_status;
    logic formatter_error;
    logic input_field_id;
    logic output_field_id;
  } sgc_status_t;

  // live flags from the scaler datapath
  typedef struct packed {
    logic fifo_almost_filled;
    logic fifo_overflow;
    logic formatter_error;
    logic input_field_id;
    logic output_field_id;
  } sgc_live_t;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } sgc_req_t;

endpackage : sgc_pkg

// *** src/sgc_sample_mux.sv ***
// Purpose: routes one of four converter samples to the sample output port
// Assumes: converter samples synchronous to the clock
// Notes: output is registered
`timescale 1ns/10ps
`default_nettype none
module sgc_sample_mux
  import sgc_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // selection and samples
  input wire logic [1:0] i_sel,
  input wire logic [4*SGC_SAMPLE_W-1:0] i_samples,
  // routed sample
  output logic [SGC_SAMPLE_W-1:0] o_sample
);

  typedef struct packed {
    logic [SGC_SAMPLE_W-1:0] sample;
  } sgc_mux_state_t;

  sgc_mux_state_t state;
  sgc_mux_state_t next_state;

  always_comb begin
    next_state = state;
    next_state.sample = i_samples[i_sel*SGC_SAMPLE_W +: SGC_SAMPLE_W];
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state.sample <= SGC_SAMPLE_RST;
    end else begin
      state <= next_state;
    end
  end

  assign o_sample = state.sample;

endmodule : sgc_sample_mux
`default_nettype wire

// *** src/sgc_status_read.sv ***
// Purpose: answers register reads with the control or live status byte
// Assumes: one read strobe per access
// Notes: status is sampled at the read edge with no synchroniser
`timescale 1ns/10ps
`default_nettype none
module sgc_status_read
  import sgc_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // request
  input wire logic i_rd,
  input wire logic [7:0] i_addr,
  // sources
  input wire sgc_ctrl_t i_ctrl,
  input wire sgc_status_t i_status,
  // answer
  output logic [7:0] o_rdata
);

  typedef struct packed {
    logic [7:0] rdata;
  } sgc_rd_state_t;

  sgc_rd_state_t state;
  sgc_rd_state_t next_state;

  always_comb begin
    next_state = state;
    if (i_rd) begin
      case (i_addr)
        SGC_ADDR_CTRL: next_state.rdata = i_ctrl;
        SGC_ADDR_STATUS: next_state.rdata = i_status;
        default: next_state.rdata = SGC_UNMAPPED_RD;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state.rdata <= SGC_RDATA_RST;
    end else begin
      state <= next_state;
    end
  end

  assign o_rdata = state.rdata;

endmodule : sgc_status_read
`default_nettype wire

// *** src/sgc_top.sv ***
// Purpose: global control byte and scaler status byte of the capture device
// Assumes: register requests arrive as byte accesses from the serial bus engine
// Notes: status reads are live snapshots, not synchronised
// Behaviour
// - programmed marker cleared by reset
// - marker mirrored into status bit three
// - soft reset zero holds scaler path idle
// - soft reset one restores scaler operation
// - two-bit select routes converter to port
// - decoder sleep powers down decoder and slicer
// - sleeping decoder: scaler needs expansion-port sources
// - scaler sleep stops scaler and image output
// - audio sleep stops generation, disables output
// - status bits seven, six show tristate pins
// - status bit five: fifo almost filled
// - status bit four: fifo overflow
// - status bit two: formatter rate error
// - status bit one: input field id
// - status bit zero: output field id
// - status read live, unlatched, at access
// - status byte read-only, writes ignored
`timescale 1ns/10ps
`default_nettype none
module sgc_top
  import sgc_pkg::*;
(
  // clock and reset
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  // register access
  input wire logic [7:0] I_REG_ADDR,
  input wire logic I_REG_WR,
  input wire logic I_REG_RD,
  input wire logic [7:0] I_REG_WDATA,
  output logic [7:0] O_REG_RDATA,
  // converter samples and sample port
  input wire logic [SGC_SAMPLE_W-1:0] I_CONV1_SAMPLE,
  input wire logic [SGC_SAMPLE_W-1:0] I_CONV2_SAMPLE,
  input wire logic [SGC_SAMPLE_W-1:0] I_CONV3_SAMPLE,
  input wire logic [SGC_SAMPLE_W-1:0] I_CONV4_SAMPLE,
  output logic [SGC_SAMPLE_W-1:0] O_CONVERTER_SAMPLE_PORT,
  // status sources
  input wire logic I_EXPANSION_TRISTATE_PIN,
  input wire logic I_IMAGE_TRISTATE_PIN,
  input wire logic I_FIFO_ALMOST_FILLED,
  input wire logic I_FIFO_OVERFLOW,
  input wire logic I_FORMATTER_ERROR,
  input wire logic I_INPUT_FIELD_ID,
  input wire logic I_OUTPUT_FIELD_ID,
  // scaler source configuration from other registers
  input wire logic I_SCALER_SRC_XPORT,
  input wire logic I_IMAGE_PORT_CLOCK_SRC_XPORT,
  // power and reset controls
  output logic O_SCALER_IDLE_HOLD,
  output logic O_SCALER_RUN,
  output logic O_DECODER_RUN,
  output logic O_SLICER_RUN,
  output logic O_IMAGE_PORT_OUT_EN,
  output logic O_AUDIO_CLOCK_RUN,
  output logic O_AUDIO_CLOCK_OUT_EN
);

  typedef struct packed {
    sgc_ctrl_t ctrl;
    logic scaler_idle_hold;
    logic scaler_run;
    logic decoder_run;
    logic audio_run;
  } sgc_top_state_t;

  sgc_top_state_t state;
  sgc_top_state_t next_state;
  sgc_req_t req;
  sgc_status_t status;
  sgc_live_t live;

  function automatic logic scaler_may_run(input sgc_ctrl_t c, input logic src_x,
                                          input logic clk_x);
    scaler_may_run = c.scaler_soft_reset_n && !c.scaler_sleep
      && (!c.decoder_sleep || (src_x && clk_x));
  endfunction : scaler_may_run

  assign req = '{addr: I_REG_ADDR, wr: I_REG_WR, rd: I_REG_RD, wdata: I_REG_WDATA};
  assign live = '{fifo_almost_filled: I_FIFO_ALMOST_FILLED,
                  fifo_overflow: I_FIFO_OVERFLOW,
                  formatter_error: I_FORMATTER_ERROR,
                  input_field_id: I_INPUT_FIELD_ID,
                  output_field_id: I_OUTPUT_FIELD_ID};

  // status byte is assembled from live levels and the programmed marker; no write path exists
  always_comb begin
    status.expansion_tristate_pin = I_EXPANSION_TRISTATE_PIN;
    status.image_tristate_pin = I_IMAGE_TRISTATE_PIN;
    status.fifo_almost_filled = live.fifo_almost_filled;
    status.fifo_overflow = live.fifo_overflow;
    status.programmed_status = state.ctrl.programmed_marker;
    status.formatter_error = live.formatter_error;
    status.input_field_id = live.input_field_id;
    status.output_field_id = live.output_field_id;
  end

  always_comb begin
    next_state = state;
    if (req.wr && (req.addr == SGC_ADDR_CTRL)) begin
      next_state.ctrl = sgc_ctrl_t'(req.wdata);
      next_state.ctrl.reserved = 1'b0;
    end
    next_state.scaler_idle_hold = !next_state.ctrl.scaler_soft_reset_n;
    next_state.scaler_run = scaler_may_run(next_state.ctrl, I_SCALER_SRC_XPORT,
                                           I_IMAGE_PORT_CLOCK_SRC_XPORT);
    next_state.decoder_run = !next_state.ctrl.decoder_sleep;
    next_state.audio_run = !next_state.ctrl.audio_clock_sleep;
  end

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      state.ctrl <= sgc_ctrl_t'(SGC_CTRL_RST);
      state.scaler_idle_hold <= 1'b1;
      state.scaler_run <= 1'b0;
      state.decoder_run <= 1'b1;
      state.audio_run <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  sgc_sample_mux u_sample_mux (
    .i_clk(I_CLK),
    .i_rst(I_SYS_RST),
    .i_sel({state.ctrl.sample_port_select_hi, state.ctrl.sample_port_select_lo}),
    .i_samples({I_CONV4_SAMPLE, I_CONV3_SAMPLE, I_CONV2_SAMPLE, I_CONV1_SAMPLE}),
    .o_sample(O_CONVERTER_SAMPLE_PORT)
  );

  sgc_status_read u_status_read (
    .i_clk(I_CLK),
    .i_rst(I_SYS_RST),
    .i_rd(req.rd),
    .i_addr(req.addr),
    .i_ctrl(state.ctrl),
    .i_status(status),
    .o_rdata(O_REG_RDATA)
  );

  assign O_SCALER_IDLE_HOLD = state.scaler_idle_hold;
  assign O_SCALER_RUN = state.scaler_run;
  assign O_DECODER_RUN = state.decoder_run;
  assign O_SLICER_RUN = state.decoder_run;
  assign O_IMAGE_PORT_OUT_EN = state.scaler_run;
  assign O_AUDIO_CLOCK_RUN = state.audio_run;
  assign O_AUDIO_CLOCK_OUT_EN = state.audio_run;

endmodule : sgc_top
`default_nettype wire

// *** sim/sgc_host_model.sv ***
// Purpose: serial bus host model
// Assumes: one strobe cycle per access
// Notes: released lines show inverse data
`timescale 1ns/10ps
`default_nettype none
module sgc_host_model (
  // clock, answer
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  // request
  output logic [7:0] o_addr,
  output logic o_wr,
  output logic o_rd,
  output logic [7:0] o_wdata
);
  initial {o_addr, o_wr, o_rd, o_wdata} = 18'h00000;
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q);
    @(negedge i_clk);
    {o_addr, o_wdata, o_wr, o_rd} = {a, d, w, !w};
    @(negedge i_clk);
    {o_addr, o_wdata, o_wr, o_rd} = {~a, ~d, 2'b00};
    q = i_rdata;
  endtask : access
endmodule : sgc_host_model
`default_nettype wire

// *** sim/sgc_top_monitor.sv ***
// Purpose: port assertions for sgc_top
// Assumes: one clock, synchronous reset
// Notes: keeps a copy of the control byte
`timescale 1ns/10ps
`default_nettype none
module sgc_top_monitor
  import sgc_pkg::*;
(
  // clock and reset
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  // register access
  input wire logic [7:0] I_REG_ADDR,
  input wire logic I_REG_WR,
  input wire logic I_REG_RD,
  input wire logic [7:0] I_REG_WDATA,
  input wire logic [7:0] O_REG_RDATA,
  // controls
  input wire logic O_SCALER_IDLE_HOLD,
  input wire logic O_SCALER_RUN,
  input wire logic O_DECODER_RUN,
  input wire logic O_SLICER_RUN,
  input wire logic O_IMAGE_PORT_OUT_EN,
  input wire logic O_AUDIO_CLOCK_RUN,
  input wire logic O_AUDIO_CLOCK_OUT_EN
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_SYS_RST);
  logic [7:0] ctrl;
  logic wc;
  assign wc = I_REG_WR && I_REG_ADDR == SGC_ADDR_CTRL;
  always_ff @(posedge I_CLK) ctrl <= I_SYS_RST ? 8'h00 : wc ? (I_REG_WDATA & 8'hfb) : ctrl;
  ctrl_read_a: assert property (I_REG_RD && I_REG_ADDR == SGC_ADDR_CTRL |=>
    O_REG_RDATA == $past(ctrl)) else $error("control readback");
  marker_copy_a: assert property (I_REG_RD && I_REG_ADDR == SGC_ADDR_STATUS |=>
    O_REG_RDATA[3] == $past(ctrl[4])) else $error("marker copy");
  idle_hold_a: assert property (wc && !I_REG_WDATA[5] |=>
    O_SCALER_IDLE_HOLD && !O_SCALER_RUN) else $error("idle hold");
  soft_run_a: assert property (wc && I_REG_WDATA[5] && I_REG_WDATA[1:0] == 2'b00 |=>
    !O_SCALER_IDLE_HOLD && O_SCALER_RUN) else $error("scaler run");
  decoder_a: assert property (wc |=> O_DECODER_RUN == !$past(I_REG_WDATA[0])
    && O_SLICER_RUN == O_DECODER_RUN) else $error("decoder sleep");
  scaler_sleep_a: assert property (wc && I_REG_WDATA[1] |=>
    !O_SCALER_RUN && !O_IMAGE_PORT_OUT_EN) else $error("scaler sleep");
  audio_sleep_a: assert property (wc |=> O_AUDIO_CLOCK_RUN == !$past(I_REG_WDATA[3])
    && O_AUDIO_CLOCK_OUT_EN == O_AUDIO_CLOCK_RUN) else $error("audio sleep");
  status_ro_a: assert property (I_REG_WR && I_REG_ADDR == SGC_ADDR_STATUS |=>
    $stable({O_DECODER_RUN, O_AUDIO_CLOCK_RUN, O_SCALER_IDLE_HOLD})) else $error("ro");
endmodule : sgc_top_monitor
bind sgc_top sgc_top_monitor sgc_top_monitor_inst (.*);
`default_nettype wire

// *** sim/tb_sgc_top.sv ***
// Purpose: self-checking bench for sgc_top
// Assumes: inputs change at the falling edge
// Notes: register traffic goes through the host model
`timescale 1ns/10ps
`default_nettype none
module tb_sgc_top;
  import sgc_pkg::*;
  logic I_CLK, I_SYS_RST, I_REG_WR, I_REG_RD, I_SCALER_SRC_XPORT, I_IMAGE_PORT_CLOCK_SRC_XPORT;
  logic [7:0] I_REG_ADDR, I_REG_WDATA, O_REG_RDATA, q;
  logic [SGC_SAMPLE_W-1:0] I_CONV1_SAMPLE, I_CONV2_SAMPLE, I_CONV3_SAMPLE, I_CONV4_SAMPLE;
  logic [SGC_SAMPLE_W-1:0] O_CONVERTER_SAMPLE_PORT, smp [4];
  logic I_EXPANSION_TRISTATE_PIN, I_IMAGE_TRISTATE_PIN, I_FIFO_ALMOST_FILLED, I_FIFO_OVERFLOW;
  logic I_FORMATTER_ERROR, I_INPUT_FIELD_ID, I_OUTPUT_FIELD_ID, O_SCALER_IDLE_HOLD;
  logic O_SCALER_RUN, O_DECODER_RUN, O_SLICER_RUN, O_IMAGE_PORT_OUT_EN;
  logic O_AUDIO_CLOCK_RUN, O_AUDIO_CLOCK_OUT_EN;
  int n_errors = 0, n_compared = 0, cyc = 0;
  assign {I_CONV1_SAMPLE, I_CONV2_SAMPLE, I_CONV3_SAMPLE, I_CONV4_SAMPLE} =
    {smp[0], smp[1], smp[2], smp[3]};
  sgc_top sgc_top_inst (.*);
  sgc_host_model sgc_host_model_inst (.i_clk(I_CLK), .i_rdata(O_REG_RDATA), .o_addr(I_REG_ADDR),
    .o_wr(I_REG_WR), .o_rd(I_REG_RD), .o_wdata(I_REG_WDATA));
  task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sgc_host_model_inst.access(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    sgc_host_model_inst.access(1'b0, a, 8'h00, q);
  endtask : rd
  task automatic put(input logic [6:0] s);
    {I_EXPANSION_TRISTATE_PIN, I_IMAGE_TRISTATE_PIN, I_FIFO_ALMOST_FILLED, I_FIFO_OVERFLOW,
     I_FORMATTER_ERROR, I_INPUT_FIELD_ID, I_OUTPUT_FIELD_ID} = s;
  endtask : put
  task automatic t_reset();
    rd(SGC_ADDR_CTRL);
    chk("ctrl", 9'h000, 9'(q));
    chk("idle", 9'h002, 9'({O_SCALER_IDLE_HOLD, O_SCALER_RUN}));
  endtask : t_reset
  task automatic t_status(input logic m);
    logic [6:0] e;
    for (int i = 0; i < 7; i++) begin
      e = 7'h01 << i;
      put(e);
      rd(SGC_ADDR_STATUS);
      chk("status", 9'({e[6:3], m, e[2:0]}), 9'(q));
    end
    put(7'h00);
  endtask : t_status
  task automatic t_select();
    for (int s = 0; s < 4; s++) begin
      wr(SGC_ADDR_CTRL, {2'(s), 6'h30});
      @(negedge I_CLK);
      chk("port", smp[s], O_CONVERTER_SAMPLE_PORT);
    end
  endtask : t_select
  task automatic t_sleep();
    {I_SCALER_SRC_XPORT, I_IMAGE_PORT_CLOCK_SRC_XPORT} = 2'b11;
    wr(SGC_ADDR_CTRL, 8'h31);
    @(negedge I_CLK);
    chk("dec", 9'h001, 9'({O_DECODER_RUN, O_SLICER_RUN, O_SCALER_RUN}));
    I_SCALER_SRC_XPORT = 1'b0;
    repeat (2) @(negedge I_CLK);
    chk("run", 9'h000, 9'(O_SCALER_RUN));
    wr(SGC_ADDR_CTRL, 8'h3a);
    chk("sleep", 9'h004, 9'({O_SCALER_RUN, O_IMAGE_PORT_OUT_EN, O_DECODER_RUN,
      O_AUDIO_CLOCK_RUN, O_AUDIO_CLOCK_OUT_EN}));
  endtask : t_sleep
  task automatic t_ro();
    wr(SGC_ADDR_CTRL, 8'h10);
    chk("idle", 9'h002, 9'({O_SCALER_IDLE_HOLD, O_SCALER_RUN}));
    wr(SGC_ADDR_CTRL, 8'h30);
    chk("resume", 9'h002, 9'({O_SCALER_RUN, O_SCALER_IDLE_HOLD}));
    wr(SGC_ADDR_STATUS, 8'hff);
    rd(SGC_ADDR_STATUS);
    chk("status", 9'h008, 9'(q));
    rd(SGC_ADDR_CTRL);
    chk("ctrl", 9'h030, 9'(q));
    rd(8'h8e);
    chk("unmapped", 9'(SGC_UNMAPPED_RD), 9'(q));
  endtask : t_ro
  task automatic t_marker();
    wr(SGC_ADDR_CTRL, 8'h30);
    t_status(1'b1);
    chk("run", 9'h00f,
      9'({O_SCALER_RUN, O_IMAGE_PORT_OUT_EN, O_AUDIO_CLOCK_RUN, O_AUDIO_CLOCK_OUT_EN}));
  endtask : t_marker
  task automatic final_report();
    if (n_errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : final_report
  initial begin
    I_CLK = 1'b0;
    forever #25 I_CLK = ~I_CLK;
  end
  always @(posedge I_CLK) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_errors++;
      final_report();
    end
  end
  initial begin
    I_SYS_RST = 1'b1;
    {I_SCALER_SRC_XPORT, I_IMAGE_PORT_CLOCK_SRC_XPORT} = 2'b00;
    put(7'h00);
    smp = '{9'h1a5, 9'h05a, 9'h133, 9'h0cc};
    repeat (20) @(negedge I_CLK);
    I_SYS_RST = 1'b0;
    t_reset();
    t_status(1'b0);
    t_marker();
    t_select();
    t_sleep();
    t_ro();
    I_SYS_RST = 1'b1;
    repeat (2) @(negedge I_CLK);
    I_SYS_RST = 1'b0;
    t_reset();
    final_report();
  end
endmodule : tb_sgc_top
`default_nettype wire
